// ===== inc/cbs_pkg.sv
// Purpose: shared constants and types of the bus cycle sequencer
// Assumes: 24-bit byte address, 16-bit data bus
// Notes:   stack grows downward, pushes predecrement the stack pointer
package cbs_pkg;
    // ------------------------------------------------------------
    // widths and addresses
    // ------------------------------------------------------------
    localparam int          ADDR_W         = 24;
    localparam int          DATA_W         = 16;
    localparam logic [23:0] RESET_VEC_ADDR = 24'h000000;
    localparam logic [23:0] WORD_STEP      = 24'h000002;
    localparam logic [23:0] PAIR_STEP      = 24'h000004;
    localparam logic [23:0] FRAME_BYTES    = 24'h000006;
    localparam logic [23:0] PTR_STEP       = 24'h000001;
    localparam logic [7:0]  TAS_SET_MASK   = 8'h80;
    localparam logic [7:0]  PAD_BYTE       = 8'h00;

    // ------------------------------------------------------------
    // sequence kinds, step actions, controller states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        K_RESET = 3'h0,
        K_EXC   = 3'h1,
        K_STM   = 3'h2,
        K_STC   = 3'h3,
        K_MOVE  = 3'h4,
        K_TAS   = 3'h5
    } cbs_kind_t;

    typedef enum logic [1:0] {
        A_NONE = 2'h0,
        A_INT  = 2'h1,
        A_RD   = 2'h2,
        A_WR   = 2'h3
    } cbs_act_t;

    typedef enum logic [1:0] {
        ST_IDLE     = 2'b00,
        ST_ISSUE    = 2'b01,
        ST_WAIT     = 2'b11,
        ST_INTERNAL = 2'b10
    } cbs_state_t;
endpackage

// ===== inc/cbs_cyc_if.sv
// Purpose: one bus cycle request from the sequencer to its bus port
// Assumes: go is a one-cycle pulse, done a one-cycle pulse
// Notes:   fields are valid only while go is high
`timescale 1ns/1ps
interface cbs_cyc_if;
    logic        go;
    logic        write;
    logic        byte_acc;
    logic        lock;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic        done;
    logic [15:0] rdata;

    modport seq  (output go, write, byte_acc, lock, addr, wdata, input done, rdata);
    modport port (input go, write, byte_acc, lock, addr, wdata, output done, rdata);
endinterface

// ===== rtl/cbs_bus_port.sv
// Purpose: hold one request on the bus controller port until acknowledged
// Assumes: bus controller logic runs on mclk and pulses bus_ack once
// Notes:   lock outlives its cycle until the next request is issued
`timescale 1ns/1ps
module cbs_bus_port
    import cbs_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    cbs_cyc_if.port          cyc,
    output logic             bus_req,
    output logic             bus_write,
    output logic             bus_byte,
    output logic             bus_lock,
    output logic [23:0]      bus_addr,
    output logic [15:0]      bus_wdata,
    input  wire logic        bus_ack,
    input  wire logic [15:0] bus_rdata
);
    // ------------------------------------------------------------
    // request hold
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
            bus_req <= 1'b0;
        else if (cyc.go)
            bus_req <= 1'b1;
        else if (bus_ack)
            bus_req <= 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            bus_write <= 1'b0;
            bus_byte  <= 1'b0;
            bus_addr  <= 24'h000000;
            bus_wdata <= 16'h0000;
        end
        else if (cyc.go)
        begin
            bus_write <= cyc.write;
            bus_byte  <= cyc.byte_acc;
            bus_addr  <= cyc.addr;
            bus_wdata <= cyc.wdata;
        end
    end

    // a linked cycle keeps the bus until the following request replaces it
    always_ff @(posedge mclk)
    begin
        if (rst)
            bus_lock <= 1'b0;
        else if (cyc.go)
            bus_lock <= cyc.lock; // RULE10
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cyc.done  <= 1'b0;
            cyc.rdata <= 16'h0000;
        end
        else
        begin
            cyc.done <= bus_req & bus_ack;
            if (bus_req & bus_ack)
                cyc.rdata <= bus_rdata;
        end
    end

    property p_lock_held;
        @(posedge mclk) disable iff (rst)
        $fell(bus_lock) |-> $past(cyc.go);
    endproperty
    a_lock_held: assert property (p_lock_held) // RULE10
        else $error("bus lock dropped without a new request");
endmodule // cbs_bus_port

// ===== rtl/cbs_sequencer.sv
// Purpose: orders the bus cycles of exception entry and multi-cycle instructions
// Assumes: start requests are single-cycle levels sampled while idle
// Notes:   one sequence at a time; reset entry starts by itself after rst
`timescale 1ns/1ps
// Behaviour
// [RULE1] reset: vector, vector+2, internal, prefetch start
// [RULE2] interrupt: prefetch, internal, push low/high/control, vector
// [RULE3] trap pushes control word, linked vector read
// [RULE4] block move from source/destination pointers, zero skips
// [RULE5] multi push: linked prefetch, internal, high/low pairs
// [RULE6] pushed return value plus two is prefetch
// [RULE7] wake from sleep replaces first prefetch internally
// [RULE8] test-and-set uses only registers zero, one, four, five
// [RULE9] control store: fetch, prefetch, internal, then write
// [RULE10] one request per access; linked cycles keep bus
module cbs_sequencer
    import cbs_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        irq_req,
    input  wire logic        trap_req,
    input  wire logic        wake_from_sleep,
    input  wire logic [23:0] vector_address,
    input  wire logic [23:0] ret_pc,
    input  wire logic [23:0] stack_pointer,
    input  wire logic [7:0]  extended_control_reg,
    input  wire logic [7:0]  condition_flags_reg,
    input  wire logic        stm_req,
    input  wire logic [2:0]  stm_reg_count,
    input  wire logic [31:0] stm_reg_data,
    input  wire logic        stc_req,
    input  wire logic        stc_use_ext,
    input  wire logic [23:0] stc_base,
    input  wire logic        move_req,
    input  wire logic        move_word_mode,
    input  wire logic [23:0] source_pointer_reg,
    input  wire logic [23:0] destination_pointer_reg,
    input  wire logic [15:0] move_count_word,
    input  wire logic        tas_req,
    input  wire logic [23:0] tas_addr,
    output logic             bus_req,
    output logic             bus_write,
    output logic             bus_byte,
    output logic             bus_lock,
    output logic [23:0]      bus_addr,
    output logic [15:0]      bus_wdata,
    input  wire logic        bus_ack,
    input  wire logic [15:0] bus_rdata,
    output logic             busy,
    output logic             seq_done,
    output logic [1:0]       stm_reg_index,
    output logic [23:0]      start_address,
    output logic [23:0]      sp_out,
    output logic [23:0]      src_ptr_out,
    output logic [23:0]      dst_ptr_out
);
    import cbs_pkg::*;

    cbs_cyc_if cyc ();

    cbs_state_t  state;
    cbs_state_t  next_state;
    cbs_kind_t   kind;
    logic [3:0]  step;
    logic [15:0] rep;
    logic        wake;
    logic [23:0] vec;
    logic [23:0] pc;
    logic [23:0] ea;
    logic [7:0]  ctl_byte;
    logic [15:0] rd_prev;
    logic [15:0] rd_last;
    cbs_act_t    act;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic        lock;
    logic        byte_acc;
    logic        last;
    logic        adv;
    logic        idle_start;
    logic [23:0] tgt;
    logic [15:0] move_count;

    assign tgt        = {rd_prev[7:0], rd_last};
    assign move_count = move_word_mode ? move_count_word : {8'h00, move_count_word[7:0]};
    assign adv        = (state == ST_INTERNAL) || (state == ST_WAIT && cyc.done);
    assign idle_start = (state == ST_IDLE)
                      && (irq_req || trap_req || stm_req || stc_req || move_req || tas_req);
    assign busy       = (state != ST_IDLE);

    // ------------------------------------------------------------
    // per-step cycle plan
    // ------------------------------------------------------------
    always_comb
    begin
        act      = A_NONE;
        addr     = 24'h000000;
        wdata    = 16'h0000;
        lock     = 1'b0;
        byte_acc = 1'b0;
        last     = 1'b0;
        case (kind)
            K_RESET:
                case (step)
                    4'h0: begin act = A_RD; addr = vec; end // RULE1
                    4'h1: begin act = A_RD; addr = vec + WORD_STEP; end // RULE1
                    4'h2: act = A_INT; // RULE1
                    default: begin act = A_RD; addr = tgt; last = 1'b1; end // RULE1
                endcase
            K_EXC:
                case (step)
                    4'h0: begin act = wake ? A_INT : A_RD; addr = pc + WORD_STEP; end // RULE6 RULE7
                    4'h1: act = A_INT;
                    4'h2: begin act = A_WR; addr = ea - WORD_STEP; wdata = pc[15:0]; end // RULE2
                    4'h3: begin act = A_WR; addr = ea - PAIR_STEP; wdata = {PAD_BYTE, pc[23:16]}; end
                    4'h4: begin act = A_WR; addr = ea - FRAME_BYTES; wdata = {PAD_BYTE, ctl_byte}; end // RULE3
                    4'h5: begin act = A_RD; addr = vec; lock = 1'b1; end // RULE3
                    4'h6: begin act = A_RD; addr = vec + WORD_STEP; end // RULE2
                    4'h7: act = A_INT;
                    default: begin act = A_RD; addr = tgt; last = 1'b1; end
                endcase
            K_STM:
                case (step)
                    4'h0: begin act = A_RD; addr = pc + WORD_STEP; lock = 1'b1; end // RULE5
                    4'h1: act = A_INT;
                    4'h2:
                    begin
                        act   = A_WR;
                        addr  = ea - PAIR_STEP;
                        wdata = stm_reg_data[31:16];
                        lock  = 1'b1; // RULE5
                    end
                    default:
                    begin
                        act   = A_WR;
                        addr  = ea - WORD_STEP;
                        wdata = stm_reg_data[15:0];
                        last  = (rep == 16'h0001);
                    end
                endcase
            K_STC:
                case (step)
                    4'h0: begin act = A_RD; addr = pc; end // RULE9
                    4'h1: begin act = A_RD; addr = pc + WORD_STEP; end
                    4'h2: act = A_INT; // RULE9
                    default:
                    begin
                        act   = A_WR;
                        addr  = ea - WORD_STEP;
                        wdata = {PAD_BYTE, ctl_byte};
                        last  = 1'b1;
                    end
                endcase
            K_MOVE:
                if (step == 4'h0)
                begin
                    act = A_RD; addr = vec; byte_acc = 1'b1; // RULE4
                end
                else
                begin
                    act = A_WR; addr = ea; byte_acc = 1'b1; // RULE4
                    wdata = {2{rd_last[7:0]}};
                    last  = (rep == 16'h0001);
                end
            K_TAS:
                if (step == 4'h0)
                begin
                    act = A_RD; addr = ea; byte_acc = 1'b1; lock = 1'b1; // RULE8
                end
                else
                begin
                    act = A_WR; addr = ea; byte_acc = 1'b1; last = 1'b1;
                    wdata = {2{rd_last[7:0] | TAS_SET_MASK}};
                end
            default: act = A_NONE;
        endcase
    end

    assign cyc.go       = (state == ST_ISSUE) && (act == A_RD || act == A_WR); // RULE10
    assign cyc.write    = (act == A_WR);
    assign cyc.byte_acc = byte_acc;
    assign cyc.lock     = lock;
    assign cyc.addr     = addr;
    assign cyc.wdata    = wdata;

    // ------------------------------------------------------------
    // controller
    // ------------------------------------------------------------
    always_comb
    begin
        case (state)
            ST_IDLE:     next_state = (idle_start && !(move_req && move_count == 16'h0000
                                       && !(irq_req || trap_req || stm_req || stc_req)))
                                      ? ST_ISSUE : ST_IDLE;
            ST_ISSUE:    next_state = (act == A_INT) ? ST_INTERNAL : ST_WAIT;
            ST_WAIT:     next_state = cyc.done ? (last ? ST_IDLE : ST_ISSUE) : ST_WAIT;
            ST_INTERNAL: next_state = last ? ST_IDLE : ST_ISSUE;
            default:     next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            state <= ST_ISSUE;
        else
            state <= next_state;
    end

    // start priority: interrupt, trap, push, store, move, test-and-set
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            kind <= K_RESET;
            step <= 4'h0;
            rep  <= 16'h0000;
            wake <= 1'b0;
        end
        else if (idle_start)
        begin
            step <= 4'h0;
            wake <= irq_req && wake_from_sleep;
            if (irq_req || trap_req)
                kind <= K_EXC;
            else if (stm_req)
            begin
                kind <= K_STM;
                rep  <= {13'h0000, stm_reg_count};
            end
            else if (stc_req)
                kind <= K_STC;
            else if (move_req)
            begin
                kind <= K_MOVE;
                rep  <= move_count; // RULE4
            end
            else
                kind <= K_TAS;
        end
        else if (adv && !last)
        begin
            if (kind == K_STM && step == 4'h3)
            begin
                step <= 4'h2; // RULE5
                rep  <= rep - 16'h0001;
            end
            else if (kind == K_MOVE && step == 4'h1)
            begin
                step <= 4'h0;
                rep  <= rep - 16'h0001;
            end
            else
                step <= step + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // operands and pointers
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            vec      <= RESET_VEC_ADDR;
            pc       <= 24'h000000;
            ea       <= 24'h000000;
            ctl_byte <= 8'h00;
        end
        else if (idle_start)
        begin
            pc       <= ret_pc;
            vec      <= (irq_req || trap_req) ? vector_address : source_pointer_reg;
            ea       <= (irq_req || trap_req || stm_req) ? stack_pointer
                      : stc_req ? stc_base : move_req ? destination_pointer_reg : tas_addr;
            ctl_byte <= (stc_req && !stc_use_ext && !(irq_req || trap_req || stm_req))
                      ? condition_flags_reg : extended_control_reg;
        end
        else if (adv)
        begin
            if (kind == K_STM && step == 4'h3)
                ea <= ea - PAIR_STEP;
            if (kind == K_EXC && step == 4'h4)
                ea <= ea - FRAME_BYTES;
            if (kind == K_STC && step == 4'h3)
                ea <= ea - WORD_STEP; // RULE9
            if (kind == K_MOVE && step == 4'h1)
            begin
                vec <= vec + PTR_STEP; // RULE4
                ea  <= ea + PTR_STEP; // RULE4
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rd_prev       <= 16'h0000;
            rd_last       <= 16'h0000;
            seq_done      <= 1'b0;
            start_address <= 24'h000000;
            stm_reg_index <= 2'h0;
        end
        else
        begin
            if (state == ST_WAIT && cyc.done)
            begin
                rd_prev <= rd_last;
                rd_last <= cyc.rdata;
            end
            seq_done <= (adv && last) || (idle_start && move_req && move_count == 16'h0000
                                          && !(irq_req || trap_req || stm_req || stc_req));
            if (adv && last && (kind == K_RESET || kind == K_EXC))
                start_address <= tgt;
            if (idle_start)
                stm_reg_index <= 2'h0;
            else if (adv && kind == K_STM && step == 4'h3)
                stm_reg_index <= stm_reg_index + 2'h1;
        end
    end

    assign sp_out      = ea;
    assign src_ptr_out = vec;
    assign dst_ptr_out = ea;

    cbs_bus_port u_port (
        .mclk      (mclk),
        .rst       (rst),
        .cyc       (cyc.port),
        .bus_req   (bus_req),
        .bus_write (bus_write),
        .bus_byte  (bus_byte),
        .bus_lock  (bus_lock),
        .bus_addr  (bus_addr),
        .bus_wdata (bus_wdata),
        .bus_ack   (bus_ack),
        .bus_rdata (bus_rdata)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_reset_entry;
        @(posedge mclk) disable iff (rst)
        (kind == K_RESET && step == 4'h1 && state == ST_WAIT && cyc.done)
        |=> state == ST_ISSUE
            ##1 state == ST_INTERNAL ##1 (cyc.go && !cyc.write && cyc.addr == tgt);
    endproperty
    a_reset_entry: assert property (p_reset_entry) // RULE1
        else $error("reset entry did not prefetch after one internal state");

    property p_exc_vector;
        @(posedge mclk) disable iff (rst)
        (cyc.go && kind == K_EXC && step == 4'h5) |-> (cyc.lock && !cyc.write && cyc.addr == vec);
    endproperty
    a_exc_vector: assert property (p_exc_vector) // RULE2
        else $error("exception vector read not linked or misaddressed");

    property p_exc_ctl_push;
        @(posedge mclk) disable iff (rst)
        (cyc.go && kind == K_EXC && step == 4'h4)
        |-> (cyc.write && cyc.wdata == {PAD_BYTE, ctl_byte} && cyc.addr == ea - FRAME_BYTES);
    endproperty
    a_exc_ctl_push: assert property (p_exc_ctl_push) // RULE3
        else $error("control word push wrong");

    property p_move_step;
        @(posedge mclk) disable iff (rst)
        (kind == K_MOVE && step == 4'h1 && state == ST_WAIT && cyc.done)
        |=> (vec == $past(vec) + PTR_STEP && ea == $past(ea) + PTR_STEP);
    endproperty
    a_move_step: assert property (p_move_step) // RULE4
        else $error("block move pointers not advanced by one");

    property p_stm_high;
        @(posedge mclk) disable iff (rst)
        (cyc.go && kind == K_STM && step == 4'h2) |-> (cyc.lock && cyc.write && !cyc.byte_acc);
    endproperty
    a_stm_high: assert property (p_stm_high) // RULE5
        else $error("high word push not linked");

    property p_ret_prefetch;
        @(posedge mclk) disable iff (rst)
        (cyc.go && kind == K_EXC && step == 4'h2)
        |-> (cyc.wdata == pc[15:0] && $past(step, 2) != 4'h2);
    endproperty
    a_ret_prefetch: assert property (p_ret_prefetch) // RULE6
        else $error("pushed return word does not match prefetch base");

    property p_wake;
        @(posedge mclk) disable iff (rst)
        (state == ST_ISSUE && kind == K_EXC && step == 4'h0 && wake)
        |-> (!cyc.go ##1 state == ST_INTERNAL);
    endproperty
    a_wake: assert property (p_wake) // RULE7
        else $error("wake-up entry issued a prefetch");

    property p_stc_write;
        @(posedge mclk) disable iff (rst)
        (cyc.go && kind == K_STC && step == 4'h3)
        |-> (cyc.write && cyc.addr == ea - WORD_STEP && $past(state) == ST_INTERNAL);
    endproperty
    a_stc_write: assert property (p_stc_write) // RULE9
        else $error("control store write not after internal state");
endmodule // cbs_sequencer

// ===== verification/cbs_bus_model.sv
// Purpose: bus controller stand-in that answers the sequencer's requests
// Assumes: one outstanding request, same clock as the sequencer
// Notes:   read data is the address folded with a pattern; idle data toggles
`timescale 1ns/1ps
module cbs_bus_model
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        slow,
    input  wire logic        bus_req,
    input  wire logic [23:0] bus_addr,
    output logic             bus_ack,
    output logic [15:0]      bus_rdata
);
    logic [1:0] wait_cnt;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            bus_ack   <= 1'b0;
            bus_rdata <= 16'h0000;
            wait_cnt  <= 2'h0;
        end
        else if (bus_req && !bus_ack && (!slow || wait_cnt == 2'h3))
        begin
            bus_ack   <= 1'b1;
            bus_rdata <= bus_addr[15:0] ^ 16'h5A5A;
            wait_cnt  <= 2'h0;
        end
        else
        begin
            // stale data is inverted so a sample one cycle late looks wrong
            bus_ack   <= 1'b0;
            bus_rdata <= ~bus_rdata;
            if (bus_req && !bus_ack)
                wait_cnt <= wait_cnt + 2'h1;
        end
    end
endmodule // cbs_bus_model

// ===== verification/cpu_bus_cycle_sequencer_bench.sv
// Purpose: self-checking bench of the bus cycle sequencer
// Assumes: model read data is address ^ 5A5A
// Notes:   each row is one expected bus cycle; reads ignore wdata
`timescale 1ns/1ps
module cpu_bus_cycle_sequencer_bench;
    import cbs_pkg::*;
    typedef struct packed {logic w; logic b; logic l; logic [23:0] a; logic [15:0] d;} cbs_row_t;
    logic        mclk = 1'b0, rst = 1'b1, slow = 1'b0, wake_from_sleep = 1'b0;
    logic        irq_req = 1'b0, trap_req = 1'b0, stm_req = 1'b0, stc_req = 1'b0;
    logic        move_req = 1'b0, tas_req = 1'b0, stc_use_ext = 1'b0, move_word_mode = 1'b0;
    logic [23:0] vector_address = 24'h0, ret_pc = 24'h001000, stack_pointer = 24'h00FF00;
    logic [23:0] stc_base = 24'h002000, source_pointer_reg = 24'h003000;
    // target pointer stands for general_reg_zero, as software must keep to
    logic [23:0] destination_pointer_reg = 24'h004000, tas_addr = 24'h005000;
    logic [7:0]  extended_control_reg = 8'h07, condition_flags_reg = 8'hC3;
    logic [2:0]  stm_reg_count = 3'h2;
    logic [15:0] move_count_word = 16'h0102;
    logic [31:0] stm_reg_data;
    logic        bus_req, bus_write, bus_byte, bus_lock, bus_ack, busy, seq_done;
    logic [23:0] bus_addr, start_address, sp_out, src_ptr_out, dst_ptr_out;
    logic [15:0] bus_wdata, bus_rdata;
    logic [1:0]  stm_reg_index;
    int          error_cnt = 0, n_tests = 0, cyc_cnt = 0;
    cbs_row_t    rows [30];

    always #12.5 mclk = ~mclk;
    assign stm_reg_data = {14'h2800, stm_reg_index, 14'h02C0, stm_reg_index};

    cbs_sequencer u_dut (.mclk(mclk), .rst(rst), .irq_req(irq_req), .trap_req(trap_req),
        .wake_from_sleep(wake_from_sleep), .vector_address(vector_address), .ret_pc(ret_pc),
        .stack_pointer(stack_pointer), .extended_control_reg(extended_control_reg),
        .condition_flags_reg(condition_flags_reg), .stm_req(stm_req),
        .stm_reg_count(stm_reg_count), .stm_reg_data(stm_reg_data), .stc_req(stc_req),
        .stc_use_ext(stc_use_ext), .stc_base(stc_base), .move_req(move_req),
        .move_word_mode(move_word_mode), .source_pointer_reg(source_pointer_reg),
        .destination_pointer_reg(destination_pointer_reg), .move_count_word(move_count_word),
        .tas_req(tas_req), .tas_addr(tas_addr), .bus_req(bus_req), .bus_write(bus_write),
        .bus_byte(bus_byte), .bus_lock(bus_lock), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_ack(bus_ack), .bus_rdata(bus_rdata), .busy(busy), .seq_done(seq_done),
        .stm_reg_index(stm_reg_index), .start_address(start_address), .sp_out(sp_out),
        .src_ptr_out(src_ptr_out), .dst_ptr_out(dst_ptr_out));
    cbs_bus_model u_bus (.mclk(mclk), .rst(rst), .slow(slow), .bus_req(bus_req),
        .bus_addr(bus_addr), .bus_ack(bus_ack), .bus_rdata(bus_rdata));

    function automatic cbs_row_t r(logic w, logic b, logic l, logic [23:0] a, logic [15:0] d);
        return '{w, b, l, a, d};
    endfunction

    task automatic print_verdict();
        $display("errors %0d, checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic fail(string m);
        error_cnt++;
        $display("Error at %0t: %s", $time, m);
    endtask

    task automatic cmp_cyc(cbs_row_t e);
        cbs_row_t g;
        g = '{bus_write, bus_byte, bus_lock, bus_addr, e.w ? bus_wdata : e.d};
        n_tests++;
        if (g !== e)
            fail($sformatf("cycle got %h want %h", g, e));
    endtask

    task automatic cmp_val(logic [23:0] g, logic [23:0] e);
        n_tests++;
        if (g !== e)
            fail($sformatf("value got %h want %h", g, e));
    endtask

    task automatic tick();
        @(posedge mclk);
        #1;
    endtask

    task automatic start(logic [5:0] k, logic [23:0] vec, logic wake);
        int n = 0;
        while (busy !== 1'b0 && n < 50)
        begin
            tick();
            n++;
        end
        @(posedge mclk);
        {irq_req, trap_req, stm_req, stc_req, move_req, tas_req} <= k;
        vector_address  <= vec;
        wake_from_sleep <= wake;
        @(posedge mclk);
        {irq_req, trap_req, stm_req, stc_req, move_req, tas_req} <= 6'h00;
    endtask

    // checks rows first..last in order, then the end pulse with no stray cycle
    task automatic run_seq(int first, int last);
        int n;
        #1;
        for (int i = first; i <= last; i++)
        begin
            n = 0;
            while (bus_req !== 1'b1 && n < 50)
            begin
                tick();
                n++;
            end
            cmp_cyc(rows[i]);
            n = 0;
            while (bus_req === 1'b1 && n < 50)
            begin
                tick();
                n++;
            end
        end
        n = 0;
        while (seq_done !== 1'b1 && n < 20)
        begin
            if (bus_req === 1'b1)
                fail("unexpected bus cycle");
            tick();
            n++;
        end
        cmp_val({23'h0, seq_done}, 24'h000001);
    endtask

    always @(posedge mclk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 5000)
        begin
            error_cnt++;
            print_verdict();
        end
    end

    initial
    begin
        rows = '{r(0,0,0,24'h000000,16'h0), r(0,0,0,24'h000002,16'h0), r(0,0,0,24'h5A5A58,16'h0),
            r(1,0,0,24'h00FEFE,16'h1000), r(1,0,0,24'h00FEFC,16'h0000),
            r(1,0,0,24'h00FEFA,16'h0007), r(0,0,1,24'h000040,16'h0),
            r(0,0,0,24'h000042,16'h0), r(0,0,0,24'h1A5A18,16'h0),
            r(0,0,0,24'h001002,16'h0), r(1,0,0,24'h00FEFE,16'h1000),
            r(1,0,0,24'h00FEFC,16'h0000), r(1,0,0,24'h00FEFA,16'h0007),
            r(0,0,1,24'h000080,16'h0), r(0,0,0,24'h000082,16'h0), r(0,0,0,24'hDA5AD8,16'h0),
            r(0,0,1,24'h001002,16'h0), r(1,0,1,24'h00FEFC,16'hA000),
            r(1,0,0,24'h00FEFE,16'h0B00), r(1,0,1,24'h00FEF8,16'hA001),
            r(1,0,0,24'h00FEFA,16'h0B01), r(0,0,0,24'h001000,16'h0),
            r(0,0,0,24'h001002,16'h0), r(1,0,0,24'h001FFE,16'h00C3),
            r(0,1,0,24'h003000,16'h0), r(1,1,0,24'h004000,16'h5A5A),
            r(0,1,0,24'h003001,16'h0), r(1,1,0,24'h004001,16'h5B5B),
            r(0,1,1,24'h005000,16'h0), r(1,1,0,24'h005000,16'hDADA)};
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        run_seq(0, 2);
        cmp_val(start_address, 24'h5A5A58);
        start(6'h20, 24'h000040, 1'b1);
        run_seq(3, 8);
        cmp_val(sp_out, 24'h00FEFA);
        cmp_val(start_address, 24'h1A5A18);
        start(6'h10, 24'h000080, 1'b1);
        run_seq(9, 15);
        @(posedge mclk);
        slow <= 1'b1;
        start(6'h08, 24'h000080, 1'b0);
        run_seq(16, 20);
        start(6'h04, 24'h000080, 1'b0);
        run_seq(21, 23);
        start(6'h02, 24'h000080, 1'b0);
        run_seq(24, 27);
        cmp_val(src_ptr_out, 24'h003002);
        cmp_val(dst_ptr_out, 24'h004002);
        @(posedge mclk);
        move_count_word <= 16'h0100;
        start(6'h02, 24'h000080, 1'b0);
        run_seq(1, 0);
        start(6'h01, 24'h000080, 1'b0);
        run_seq(28, 29);
        @(posedge mclk);
        rst <= 1'b1;
        tick();
        tick();
        cmp_val({22'h0, bus_req, busy}, 24'h000001);
        print_verdict();
    end
endmodule // cpu_bus_cycle_sequencer_bench
